/* File: shared/cis_map.svh */
/*
 Constants of the charge integration sequencer: counts, times and widths.
 Assumes the system clock of the design runs at the period given here.
*/
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

// =====================================================================
// Channel array and data widths
`define CIS_NCH           64
`define CIS_DW            16

// =====================================================================
// Timing, in nanoseconds and in system clocks
`define CIS_CLK_NS        100
`define CIS_TAU_NS        1000
// The filter time constant is a model figure, so it rounds down.
`define CIS_TAU_CYC       (`CIS_TAU_NS / `CIS_CLK_NS)

// =====================================================================
// Scan clock edge counts
`define CIS_RSW_FALLS_SEQ 8'h20
`define CIS_RSW_FALLS_SIM 8'h08
`define CIS_BYP_FALLS     8'h40
`define CIS_READ_CLKS_SEQ 8'h85
`define CIS_READ_CLKS_SIM 8'h21
`define CIS_CNT_ONE       8'h01
`define CIS_CNT_ZERO      8'h00

`endif

/* File: shared/cis_pkg.sv */
/*
 Types of the charge integration sequencer: scan phases and pin bundle.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

// =====================================================================
// Phase of the integration function, and the controller's pin group
package cis_pkg;
	typedef enum logic [1:0] {PH_IDLE, PH_RESET, PH_INTEG} cis_phase_t;

	// Strobes, scan clock and mode straps from the timing controller.
	typedef struct packed {
		logic       integrator_reset_strobe;
		logic       reset_sample_strobe;
		logic       signal_sample_strobe;
		logic       integrate_window;
		logic       scan_clock;
		logic       readout_start_pulse;
		logic       charge_dump_ctrl;
		logic       polarity_select;
		logic       output_mode_select;
		logic [2:0] range_select;
	} cis_pins_t;
endpackage

`default_nettype wire

/* File: hdl/cis_sequencer.sv */
/*
 Digital model of the integration side of a multi-channel charge
 integrating front end: reset phase, integration, correlated double
 sampling and the readout-active flag.
 Assumes the controller pins are asynchronous to clk_sys and that the
 pixel currents, dump level and references are steady levels on clk_sys.
*/
`include "cis_map.svh"
`default_nettype none

// Behaviour
// [RULE1] Dump input injects compensation into each integrator.
// [RULE2] Integrate only while reset switch is open.
// [RULE3] Output is signal sample minus reset sample.
// [RULE4] Controller sequences strobes, window and clock.
// [RULE5] Readout-active low while a data read runs.
// [RULE6] Reset strobe rise starts, sample rise ends reset.
// [RULE7] All channels reset together.
// [RULE8] Reset level follows polarity select.
// [RULE9] Reset switch closed 32 or 8 clocks.
// [RULE10] Reset filter bypass opens on falling clock 64.
// [RULE11] Reset-sample rise holds the reset level.
// [RULE12] Integration follows the reset sample.
// [RULE13] Integration clamps at the opposite reference.
// [RULE14] Controller holds window over the pixel switch.
// [RULE15] Integration ignores the integrate window.
// [RULE16] Window high bypasses signal filter; fall enables.
// [RULE17] Controller waits filter settling before signal sample.
// [RULE18] Signal-sample rise captures every channel.
// [RULE19] Signal-sample fall ends integration, results stored.
// [RULE20] Polarity high selects integrate-down mode.
// [RULE21] Mode select high selects simultaneous output.
// [RULE22] Three-bit range code, bit two most significant.
// [RULE23] Controller issues strobes in fixed order.
module cis_sequencer
	import cis_pkg::*;
#(
	parameter int NCH = `CIS_NCH,
	parameter int DW  = `CIS_DW
) (
	// Clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	// Controller pins, asynchronous
	input  wire cis_pins_t                      pins,
	// Analog stand-ins, steady on clk_sys
	input  wire logic [NCH-1:0][DW-1:0]         pix_current,
	input  wire logic [DW-1:0]                  dump_level,
	input  wire logic [DW-1:0]                  high_reference,
	input  wire logic [DW-1:0]                  low_reference,
	// Result read port
	input  wire logic [$clog2(NCH)-1:0]         rd_chan,
	output logic [DW-1:0]                       result_pos,
	output logic [DW-1:0]                       result_neg,
	// Status
	output logic                                readout_active_n,
	output logic                                reset_switch_closed,
	output logic                                reset_bypass_closed
);

	// =================================================================
	// Pin synchroniser
	cis_pins_t s1_q, s2_q, s3_q, stb_q, prv_q;
	cis_pins_t s1_d, s2_d, s3_d, stb_d, prv_d;

	// A bit is taken only when the second and third stages agree.
	always_comb begin
		s1_d  = pins;
		s2_d  = s1_q;
		s3_d  = s2_q;
		stb_d = (s3_q & ~(s2_q ^ s3_q)) | (stb_q & (s2_q ^ s3_q));
		prv_d = stb_q;
	end

	// Registers of the synchroniser.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			stb_q <= '0;
			prv_q <= '0;
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			stb_q <= stb_d;
			prv_q <= prv_d;
		end
	end

	// Edge pulses of the filtered pins.
	logic integrator_reset_strobe_rise, shr_rise, shs_rise, shs_fall;
	logic sclk_rise, sclk_fall, sti_rise, sti_fall, dump_rise;
	assign integrator_reset_strobe_rise = stb_q.integrator_reset_strobe & ~prv_q.integrator_reset_strobe;
	assign shr_rise  = stb_q.reset_sample_strobe & ~prv_q.reset_sample_strobe;
	assign shs_rise  = stb_q.signal_sample_strobe & ~prv_q.signal_sample_strobe;
	assign shs_fall  = ~stb_q.signal_sample_strobe & prv_q.signal_sample_strobe;
	assign sclk_rise = stb_q.scan_clock & ~prv_q.scan_clock;
	assign sclk_fall = ~stb_q.scan_clock & prv_q.scan_clock;
	assign sti_rise  = stb_q.readout_start_pulse & ~prv_q.readout_start_pulse;
	assign sti_fall  = ~stb_q.readout_start_pulse & prv_q.readout_start_pulse;
	assign dump_rise = stb_q.charge_dump_ctrl & ~prv_q.charge_dump_ctrl;

	// =================================================================
	// Phase sequencing and switch control
	cis_phase_t phase_q, phase_d;
	logic [7:0] fcnt_q, fcnt_d, rcnt_q, rcnt_d, rsw_lim, rd_lim;
	logic       rsw_q, rsw_d, byp_q, byp_d, act_n_q, act_n_d, commit;

	// Mode select high means simultaneous output: short reset and read.
	assign rsw_lim = stb_q.output_mode_select ? `CIS_RSW_FALLS_SIM : `CIS_RSW_FALLS_SEQ;
	assign rd_lim  = stb_q.output_mode_select ? `CIS_READ_CLKS_SIM : `CIS_READ_CLKS_SEQ;
	assign commit  = (phase_q == PH_INTEG) && shs_fall;

	// A reset strobe restarts the scan from any phase.
	always_comb begin
		phase_d = phase_q;
		fcnt_d  = fcnt_q;
		rsw_d   = rsw_q;
		byp_d   = byp_q;
		rcnt_d  = rcnt_q;
		act_n_d = act_n_q;
		unique case (phase_q)
			PH_RESET: if (shr_rise) phase_d = PH_INTEG;  // RULE6 RULE12
			PH_INTEG: if (shs_fall) phase_d = PH_IDLE;   // RULE19
			PH_IDLE:  ;
		endcase
		if (integrator_reset_strobe_rise) begin
			phase_d = PH_RESET;                          // RULE6
			fcnt_d  = `CIS_CNT_ZERO;
			rsw_d   = 1'b1;                              // RULE7
			byp_d   = 1'b1;                              // RULE10
		end else if (sclk_fall && fcnt_q != `CIS_BYP_FALLS) begin
			fcnt_d = fcnt_q + `CIS_CNT_ONE;
			if (fcnt_d == rsw_lim)
				rsw_d = 1'b0;                            // RULE9
			if (fcnt_d == `CIS_BYP_FALLS)
				byp_d = 1'b0;                            // RULE10
		end
		// The read window runs from the start pulse fall over the read clocks.
		if (sti_rise) begin
			rcnt_d = `CIS_CNT_ZERO;
		end else if (sti_fall) begin
			rcnt_d  = `CIS_CNT_ZERO;
			act_n_d = 1'b0;                              // RULE5
		end else if (!act_n_q && sclk_rise) begin
			rcnt_d = rcnt_q + `CIS_CNT_ONE;
			if (rcnt_d == rd_lim)
				act_n_d = 1'b1;                          // RULE5
		end
	end

	// Registers of the sequencer.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_IDLE;
			fcnt_q  <= `CIS_CNT_ZERO;
			rsw_q   <= 1'b0;
			byp_q   <= 1'b0;
			rcnt_q  <= `CIS_CNT_ZERO;
			act_n_q <= 1'b1;
		end else begin
			phase_q <= phase_d;
			fcnt_q  <= fcnt_d;
			rsw_q   <= rsw_d;
			byp_q   <= byp_d;
			rcnt_q  <= rcnt_d;
			act_n_q <= act_n_d;
		end
	end

	// =================================================================
	// Channel datapath
	logic [DW-1:0]      integ_q [NCH], integ_d [NCH], shrt_q [NCH], shrt_d [NCH];
	logic [DW-1:0]      shrh_q [NCH], shrh_d [NCH], shst_q [NCH], shst_d [NCH];
	logic signed [DW:0] cds_q [NCH], cds_d [NCH], res_q [NCH], res_d [NCH];
	logic [DW-1:0]      rst_lvl;

	// Up mode resets to the low reference, down mode to the high one.
	assign rst_lvl = stb_q.polarity_select ? high_reference : low_reference; // RULE8

	// Low-pass tracking of a sample capacitor; each clock moves it a tenth of the way to its source.
	function automatic logic [DW-1:0] lp_step(input logic [DW-1:0] trk,
	                                          input logic [DW-1:0] src);
		logic signed [DW+1:0] dif;
		logic signed [DW+1:0] nxt;
		dif = $signed({2'b00, src}) - $signed({2'b00, trk});
		// The divide runs at integer width, so it is cut back to the width of dif.
		nxt = $signed({2'b00, trk}) + (DW+2)'(dif / `CIS_TAU_CYC);
		return nxt[DW-1:0];
	endfunction

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic signed [DW+1:0] dlt, sum;
		logic                 dn;

		// The window plays no part in accumulation, only in filtering.
		always_comb begin
			dlt = $signed({2'b00, pix_current[i] >> stb_q.range_select}); // RULE22
			dn  = stb_q.polarity_select;
			if (dump_rise) begin
				dlt = $signed({2'b00, dump_level});     // RULE1
				dn  = ~stb_q.polarity_select;
			end
			sum = dn ? $signed({2'b00, integ_q[i]}) - dlt
			         : $signed({2'b00, integ_q[i]}) + dlt;
			if (sum > $signed({2'b00, high_reference}))
				sum = $signed({2'b00, high_reference}); // RULE13
			if (sum < $signed({2'b00, low_reference}))
				sum = $signed({2'b00, low_reference});  // RULE13
			integ_d[i] = rsw_q ? rst_lvl : sum[DW-1:0]; // RULE2 RULE15
			shrt_d[i]  = byp_q ? integ_q[i] : lp_step(shrt_q[i], integ_q[i]);
			shst_d[i]  = stb_q.integrate_window ? integ_q[i]
			                                    : lp_step(shst_q[i], integ_q[i]); // RULE16
			shrh_d[i]  = (shr_rise && phase_q == PH_RESET) ? shrt_q[i] : shrh_q[i]; // RULE11
			cds_d[i]   = cds_q[i];
			if (shs_rise && phase_q == PH_INTEG)
				cds_d[i] = $signed({1'b0, shst_q[i]}) - $signed({1'b0, shrh_q[i]}); // RULE3 RULE18
			res_d[i]   = commit ? cds_q[i] : res_q[i];  // RULE19
		end

		// Registers of one channel.
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				integ_q[i] <= '0;
				shrt_q[i]  <= '0;
				shrh_q[i]  <= '0;
				shst_q[i]  <= '0;
				cds_q[i]   <= '0;
				res_q[i]   <= '0;
			end else begin
				integ_q[i] <= integ_d[i];
				shrt_q[i]  <= shrt_d[i];
				shrh_q[i]  <= shrh_d[i];
				shst_q[i]  <= shst_d[i];
				cds_q[i]   <= cds_d[i];
				res_q[i]   <= res_d[i];
			end
		end
	end

	// =================================================================
	// Differential result port
	logic               pol_q, pol_d;
	logic [DW-1:0]      pos_q, pos_d, neg_q, neg_d;
	logic signed [DW+1:0] rd;

	// The polarity of a result is latched with it, so a later strap
	// change cannot flip the sign of stored data.
	always_comb begin
		pol_d = commit ? stb_q.polarity_select : pol_q;
		rd    = $signed({res_q[rd_chan][DW], res_q[rd_chan]});
		if (pol_q) begin
			neg_d = DW'($signed({2'b00, high_reference}) + rd); // RULE3
			pos_d = DW'($signed({2'b00, low_reference}) - rd);
		end else begin
			neg_d = DW'($signed({2'b00, low_reference}) + rd);
			pos_d = DW'($signed({2'b00, high_reference}) - rd);
		end
	end

	// Registers of the result port.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pol_q <= 1'b0;
			pos_q <= '0;
			neg_q <= '0;
		end else begin
			pol_q <= pol_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	assign result_pos          = pos_q;
	assign result_neg          = neg_q;
	assign readout_active_n    = act_n_q;
	assign reset_switch_closed = rsw_q;
	assign reset_bypass_closed = byp_q;

	// =================================================================
	// Checks on channel 0 and the sequencer
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_RESET_START: assert property (integrator_reset_strobe_rise |=> phase_q == PH_RESET && rsw_q && byp_q) // RULE6
		else $error("reset phase did not start");
	AST_RESET_END: assert property (phase_q == PH_RESET && shr_rise && !integrator_reset_strobe_rise
		|=> phase_q == PH_INTEG) // RULE6
		else $error("reset phase did not end on reset sample");
	AST_RSW_OPEN: assert property (sclk_fall && !integrator_reset_strobe_rise && rsw_q
		&& fcnt_q + `CIS_CNT_ONE == rsw_lim |=> !rsw_q) // RULE9
		else $error("reset switch did not open at its clock");
	AST_BYP_OPEN: assert property (sclk_fall && !integrator_reset_strobe_rise
		&& fcnt_q + `CIS_CNT_ONE == `CIS_BYP_FALLS |=> !byp_q ##1 !byp_q) // RULE10
		else $error("reset filter bypass did not open");
	AST_HOLD_LEVEL: assert property (rsw_q && $past(rsw_q) |-> integ_q[0] == $past(rst_lvl)) // RULE8
		else $error("integrator left its reset level");
	AST_SHR_HOLD: assert property (shr_rise && phase_q == PH_RESET
		|=> shrh_q[0] == $past(shrt_q[0])) // RULE11
		else $error("reset sample not held");
	AST_WIN_TRACK: assert property (stb_q.integrate_window |=> shst_q[0] == $past(integ_q[0])) // RULE16
		else $error("signal filter not bypassed");
	AST_CDS: assert property (shs_rise && phase_q == PH_INTEG
		|=> cds_q[0] == $signed({1'b0, $past(shst_q[0])}) - $signed({1'b0, $past(shrh_q[0])})) // RULE18
		else $error("double sample difference wrong");
	AST_COMMIT: assert property (commit && !integrator_reset_strobe_rise
		|=> phase_q == PH_IDLE && res_q[0] == $past(cds_q[0])) // RULE19
		else $error("results not stored at integration end");
	AST_EOC: assert property (sti_fall |=> !readout_active_n ##1 !readout_active_n) // RULE5
		else $error("readout flag not low during read");
endmodule

`default_nettype wire

/* File: bench/cis_ctrl_model.sv */
/*
 Timing controller model for the charge integration sequencer bench.
 Assumes one bench process calls its tasks; the pins change just after
 a rising edge of clk_sys and each change is held for four edges.
*/
`default_nettype none

// =====================================================================
// Controller model
module cis_ctrl_model
	import cis_pkg::*;
(
	// Clock
	input  wire logic     clk_sys,
	// Controller pins and pixel switch
	output var cis_pins_t pins,
	output var logic      pix_on
);
	timeunit 1ns;
	timeprecision 1ns;

	cis_pins_t c;
	logic      pix_c;

	// The scan clock idles high, so that the first edge of a frame is a fall.
	initial begin
		c = '0;
		c.scan_clock = 1'b1;
		pix_c = 1'b0;
		pins = c;
		pix_on = 1'b0;
	end

	// Four edges per change, above the two the synchroniser needs.
	task automatic push();
		@(posedge clk_sys);
		pins <= c;
		pix_on <= pix_c;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic straps(input logic pol, input logic smt, input logic [2:0] rng);
		c.polarity_select = pol;
		c.output_mode_select = smt;
		c.range_select = rng;
		push();
	endtask

	task automatic integrator_reset_strobe_rise();
		c.integrator_reset_strobe = 1'b1;
		push();
	endtask

	// The clock stands still between frames.
	task automatic sclk(input int n);
		repeat (n) begin
			c.scan_clock = 1'b0;
			push();
			c.scan_clock = 1'b1;
			push();
		end
	endtask

	task automatic sti_pulse();
		c.readout_start_pulse = 1'b1;
		push();
		c.readout_start_pulse = 1'b0;
		push();
	endtask

	// Pixel current flows only while the window is up, never in the reset phase.
	// A dump, when asked for, rises as the pixel switch turns off and falls
	// with the window, so the signal sample still tracks its effect.
	task automatic integrate(input int hold, input logic dmp);
		c.integrator_reset_strobe = 1'b0;
		c.reset_sample_strobe = 1'b1;
		push();
		repeat (4) @(posedge clk_sys);
		pix_c = 1'b1;
		c.integrate_window = 1'b1;
		push();
		repeat (hold) @(posedge clk_sys);
		pix_c = 1'b0;
		c.charge_dump_ctrl = dmp;
		push();
		repeat (1) @(posedge clk_sys);
		c.integrate_window = 1'b0;
		c.charge_dump_ctrl = 1'b0;
		push();
		repeat (12) @(posedge clk_sys);
		c.signal_sample_strobe = 1'b1;
		push();
		c.signal_sample_strobe = 1'b0;
		push();
		c.reset_sample_strobe = 1'b0;
		push();
	endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
/*
 Self-checking bench of the charge integration sequencer: reset phase
 timing, double sampled results in every range and mode, readout flag.
 Assumes the controller model drives all pins; dump runs in range codes 4 to 7.
*/
`default_nettype none

// =====================================================================
// Bench top
module tb
	import cis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [15:0] LO = 16'h1000;
	localparam logic [15:0] HI = 16'h9000;
	localparam logic [15:0] DMP = 16'h0400;

	logic                  clk_sys = 1'b0;
	logic                  rst_n;
	cis_pins_t             pins;
	logic                  pix_on;
	logic [63:0][15:0]     pix_current;
	logic [5:0]            rd_chan;
	logic [15:0]           result_pos;
	logic [15:0]           result_neg;
	logic                  ro_n;
	logic                  sw;
	logic                  byp;
	int                    mismatches = 0;
	int                    tests_run = 0;

	always #50 clk_sys = ~clk_sys;

	// Channel 63 stays dark so it shows a zero difference; the rest saturate.
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			pix_current[i] = (pix_on && i != 63) ? 16'hffff : 16'h0000;
		end
	end

	cis_ctrl_model ctl_u (.clk_sys(clk_sys), .pins(pins), .pix_on(pix_on));

	cis_sequencer dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .pix_current(pix_current),
		.dump_level(DMP), .high_reference(HI), .low_reference(LO),
		.rd_chan(rd_chan), .result_pos(result_pos), .result_neg(result_neg),
		.readout_active_n(ro_n), .reset_switch_closed(sw), .reset_bypass_closed(byp)
	);

	// Sample one nanosecond after the edge so the edge's updates have landed.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		#1;
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic rd(input logic [5:0] ch, input logic [15:0] ep, input logic [15:0] en);
		@(posedge clk_sys);
		rd_chan <= ch;
		repeat (2) @(posedge clk_sys);
		chk(result_pos, ep, "result pos");
		chk(result_neg, en, "result neg");
	endtask

	// Checks one fall before and at each switching count.
	task automatic reset_phase(input logic smt);
		int n;
		n = smt ? 8 : 32;
		ctl_u.integrator_reset_strobe_rise();
		ctl_u.sclk(n - 1);
		chk(16'(sw), 16'h0001, "switch held");
		chk(16'(byp), 16'h0001, "bypass held");
		ctl_u.sclk(1);
		chk(16'(sw), 16'h0000, "switch open");
		ctl_u.sclk(63 - n);
		chk(16'(byp), 16'h0001, "bypass before last");
		ctl_u.sclk(1);
		chk(16'(byp), 16'h0000, "bypass open");
	endtask

	// A dark channel keeps the reset level, a lit one clamps at the far one.
	// A dump pulls a clamped channel back towards its reset level by DMP,
	// while the dark one is held by the clamp and shows no change.
	task automatic scan(input logic pol, input logic smt, input logic [2:0] rng,
	                    input logic dmp);
		logic [15:0] zp;
		logic [15:0] zn;
		logic [15:0] d;
		zp = pol ? LO : HI;
		zn = pol ? HI : LO;
		d = dmp ? DMP : 16'h0000;
		ctl_u.straps(pol, smt, rng);
		reset_phase(smt);
		ctl_u.integrate(120, dmp);
		repeat (4) @(posedge clk_sys);
		rd(6'h3f, zp, zn);
		rd(6'h00, pol ? HI - d : LO + d, pol ? LO + d : HI - d);
		$display("scan done pol %b smt %b range %0d dump %b", pol, smt, rng, dmp);
	endtask

	task automatic readout(input logic smt);
		int n;
		n = smt ? 33 : 133;
		ctl_u.straps(1'b0, smt, 3'h0);
		chk(16'(ro_n), 16'h0001, "idle before read");
		ctl_u.sti_pulse();
		ctl_u.sclk(n - 1);
		chk(16'(ro_n), 16'h0000, "read busy");
		ctl_u.sclk(1);
		repeat (3) @(posedge clk_sys);
		chk(16'(ro_n), 16'h0001, "read done");
		$display("readout done smt %b", smt);
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: reset, all eight range codes across modes, then reads.
	initial begin
		rst_n = 1'b0;
		rd_chan = 6'h00;
		repeat (3) @(posedge clk_sys);
		chk(16'(ro_n), 16'h0001, "reset flag");
		chk(16'(sw), 16'h0000, "reset switch");
		@(posedge clk_sys);
		rst_n <= 1'b1;
		for (int r = 0; r < 8; r++) begin
			scan(r[0], r[1], r[2:0], r[2]);
		end
		readout(1'b0);
		readout(1'b1);
		give_verdict();
	end

	// Whole run is near 7000 cycles; cut off well beyond that.
	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict();
	end
endmodule

`default_nettype wire
